// ### hdl/eeprom_ctrl_consts.svh
// offsets, field positions, reset values and widths of the eeprom command/status block
`ifndef EEPROM_CTRL_CONSTS_SVH
`define EEPROM_CTRL_CONSTS_SVH

`define APB_ADDR_W 12
`define APB_DATA_W 32

`define OFF_CONTROLLER_MODE 12'h000
`define OFF_TRANSFER_LAUNCH 12'h004
`define OFF_TRANSFER_STATE 12'h008
`define OFF_IRQ_MASK 12'h00C

`define MODE_ON_BIT 0
`define MODE_SOFT_RST_BIT 1

`define EXEC_COUNT_HI 28
`define EXEC_COUNT_LO 24
`define EXEC_CMD_HI 18
`define EXEC_CMD_LO 16
`define EXEC_PTR_HI 15
`define EXEC_PTR_LO 0
`define EXEC_WR_MASK 32'h1F07_FFFF

`define STAT_DONE_BIT 0
`define STAT_BAD_BIT 1
`define STAT_RUN_BIT 8

`define RESET_WORD 32'h0000_0000

`define FAB_ADDR_W 11
`define BUF_IDX_W 5
`define BYTE_W 8
`define CNT_W 6
`define FULL_PAGE 6'h20
`define FLAG_N 2
`endif

// ### hdl/eeprom_ctrl_pkg.sv
// types shared by the eeprom command/status block
`include "eeprom_ctrl_consts.svh"
package eeprom_ctrl_pkg;

  typedef enum logic [2:0] {
    CMD_ARRAY_READ = 3'h0,
    CMD_ARRAY_WRITE = 3'h1,
    CMD_FETCH_PROT = 3'h2,
    CMD_STORE_PROT = 3'h3
  } cmd_t;

  typedef struct packed {
    logic [`CNT_W-2:0] byte_count;
    logic [2:0] cmd;
    logic [`EXEC_PTR_HI:0] array_byte_pointer;
  } launch_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic prot;
    logic [`FAB_ADDR_W-1:0] addr;
    logic [`BYTE_W-1:0] wdata;
  } fab_req_t;

  typedef struct packed {
    logic [`BUF_IDX_W-1:0] raddr;
    logic we;
    logic [`BUF_IDX_W-1:0] waddr;
    logic [`BYTE_W-1:0] wdata;
  } buf_req_t;

endpackage

// ### hdl/sticky_flags.sv
// sticky event flags, set wins over write-one-to-clear
`timescale 1ns/1ps
`include "eeprom_ctrl_consts.svh"
module sticky_flags #(
  parameter int N = `FLAG_N
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sync_clr,
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] flags
);

  generate
    if (N < 1)
    begin : g_chk
      $error("sticky_flags needs at least one flag");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_flag
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          flags[i] <= 1'b0;
        else if (sync_clr)
          flags[i] <= 1'b0;
        else if (set[i])
          flags[i] <= 1'b1;
        else if (clr[i])
          flags[i] <= 1'b0;
      end
    end
  endgenerate

endmodule

// ### hdl/xfer_seq.sv
// byte sequencer moving data between the eeprom fabric and the register buffer
`timescale 1ns/1ps
`include "eeprom_ctrl_consts.svh"
module xfer_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sync_clr,
  input wire logic start,
  input eeprom_ctrl_pkg::launch_t launch,
  input wire logic fab_ack,
  input wire logic [`BYTE_W-1:0] fab_rdata,
  input wire logic [`BYTE_W-1:0] buf_rdata,
  output logic busy,
  output logic done,
  output eeprom_ctrl_pkg::fab_req_t fab_req,
  output eeprom_ctrl_pkg::buf_req_t buf_req
);
  import eeprom_ctrl_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_FETCH = 5'b00010,
    S_LATCH = 5'b00100,
    S_ACCESS = 5'b01000,
    S_FINISH = 5'b10000
  } seq_state_t;

  seq_state_t state_r;
  logic [`CNT_W-1:0] left_r;
  logic [`BUF_IDX_W-1:0] idx_r;
  logic is_wr;
  logic is_prot;
  logic [`CNT_W-1:0] count_nxt;
  logic buf_we_r;
  logic [`BUF_IDX_W-1:0] buf_waddr_r;
  logic [`BYTE_W-1:0] buf_wdata_r;

  always_comb
  begin
    is_wr = (launch.cmd == CMD_ARRAY_WRITE) || (launch.cmd == CMD_STORE_PROT);
    is_prot = (launch.cmd == CMD_FETCH_PROT) || (launch.cmd == CMD_STORE_PROT);
    // protection bytes move exactly one byte
    if (is_prot)
      count_nxt = `CNT_W'(1);
    else if (launch.byte_count == '0)
      count_nxt = `FULL_PAGE;
    else
      count_nxt = {1'b0, launch.byte_count};
  end

  assign busy = (state_r != S_IDLE);
  assign done = (state_r == S_FINISH);
  assign buf_req = {idx_r, buf_we_r, buf_waddr_r, buf_wdata_r};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= S_IDLE;
      left_r <= '0;
      idx_r <= '0;
      fab_req <= '0;
    end
    else if (sync_clr)
    begin
      state_r <= S_IDLE;
      left_r <= '0;
      idx_r <= '0;
      fab_req <= '0;
    end
    else
    begin
      case (state_r)
        S_IDLE:
        begin
          if (start)
          begin
            left_r <= count_nxt;
            idx_r <= '0;
            fab_req.wr <= is_wr;
            fab_req.prot <= is_prot;
            // pointer only steers array commands
            fab_req.addr <= is_prot ? '0 : launch.array_byte_pointer[`FAB_ADDR_W-1:0];
            if (is_wr)
              state_r <= S_FETCH;
            else
            begin
              fab_req.req <= 1'b1;
              state_r <= S_ACCESS;
            end
          end
        end
        S_FETCH:
          state_r <= S_LATCH;
        S_LATCH:
        begin
          fab_req.wdata <= buf_rdata;
          fab_req.req <= 1'b1;
          state_r <= S_ACCESS;
        end
        S_ACCESS:
        begin
          if (fab_ack)
          begin
            fab_req.req <= 1'b0;
            left_r <= left_r - `CNT_W'(1);
            idx_r <= idx_r + `BUF_IDX_W'(1);
            fab_req.addr <= fab_req.addr + `FAB_ADDR_W'(1);
            if (left_r == `CNT_W'(1))
              state_r <= S_FINISH;
            else if (fab_req.wr)
              state_r <= S_FETCH;
            else
              fab_req.req <= 1'b1;
          end
        end
        S_FINISH:
          state_r <= S_IDLE;
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // read bytes land in the buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buf_we_r <= 1'b0;
      buf_waddr_r <= '0;
      buf_wdata_r <= '0;
    end
    else
    begin
      buf_we_r <= (state_r == S_ACCESS) && fab_ack && !fab_req.wr && !sync_clr;
      if ((state_r == S_ACCESS) && fab_ack)
      begin
        buf_waddr_r <= idx_r;
        buf_wdata_r <= fab_rdata;
      end
    end
  end

endmodule

// ### hdl/eeprom_command_status_ctrl.sv
// apb register file, command launch, status flags and interrupt of the eeprom controller
`timescale 1ns/1ps
`include "eeprom_ctrl_consts.svh"
module eeprom_command_status_ctrl #(
  parameter int FAB_ADDR_W = `FAB_ADDR_W,
  parameter int BUF_IDX_W = `BUF_IDX_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [`APB_DATA_W-1:0] pwdata,
  output logic [`APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic fabric_power_en,
  output logic block_local_reset,
  output eeprom_ctrl_pkg::fab_req_t fab_req,
  input wire logic fab_ack,
  input wire logic [`BYTE_W-1:0] fab_rdata,
  output eeprom_ctrl_pkg::buf_req_t buf_req,
  input wire logic [`BYTE_W-1:0] buf_rdata
);
  import eeprom_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  generate
    if (FAB_ADDR_W != `FAB_ADDR_W)
    begin : g_fab_chk
      $error("fabric address width must match the 2K array");
    end
    if (BUF_IDX_W != `BUF_IDX_W)
    begin : g_buf_chk
      $error("buffer index width must match the 32-byte buffer");
    end
    if (`APB_DATA_W != 32)
    begin : g_data_chk
      $error("register words are 32 bits wide");
    end
    if (`EXEC_COUNT_HI - `EXEC_COUNT_LO + 2 != `CNT_W)
    begin : g_cnt_chk
      $error("count register must hold a full 32-byte page");
    end
    if (`FLAG_N <= `STAT_BAD_BIT)
    begin : g_flag_chk
      $error("status flags must cover both event bits");
    end
    if (FAB_ADDR_W > `EXEC_PTR_HI + 1)
    begin : g_ptr_chk
      $error("fabric address must fit in the pointer field");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  logic controller_on_r;
  logic local_rst_r;
  launch_t launch_r;
  logic [1:0] irq_mask_r;
  logic [`FLAG_N-1:0] flags;
  logic [`FLAG_N-1:0] flag_set;
  logic [`FLAG_N-1:0] flag_clr;
  logic xfer_running;
  logic xfer_finished;
  logic [`APB_DATA_W-1:0] rd_nxt;
  logic [`APB_DATA_W-1:0] mode_word;
  logic [`APB_DATA_W-1:0] launch_word;
  logic [`APB_DATA_W-1:0] state_word;
  logic [`APB_DATA_W-1:0] mask_word;
  logic hit_mode;
  logic hit_launch;
  logic hit_state;
  logic hit_mask;
  logic hit_any;
  logic setup;
  logic access;
  logic wr;
  logic launch_wr;
  logic cmd_bad;
  logic launch_bad;
  logic launch_go;
  launch_t launch_in;

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  always_comb
  begin
    hit_mode = 1'b0;
    hit_launch = 1'b0;
    hit_state = 1'b0;
    hit_mask = 1'b0;
    if (paddr == `OFF_CONTROLLER_MODE)
      hit_mode = 1'b1;
    else if (paddr == `OFF_TRANSFER_LAUNCH)
      hit_launch = 1'b1;
    else if (paddr == `OFF_TRANSFER_STATE)
      hit_state = 1'b1;
    else if (paddr == `OFF_IRQ_MASK)
      hit_mask = 1'b1;
  end

  assign hit_any = hit_mode | hit_launch | hit_state | hit_mask;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite & hit_any;
  assign pready = 1'b1;
  assign pslverr = access & ~hit_any;

  ////////////////////////////////////////////////////////////////////////////////
  // command qualification

  always_comb
  begin
    launch_in.byte_count = pwdata[`EXEC_COUNT_HI:`EXEC_COUNT_LO];
    launch_in.cmd = pwdata[`EXEC_CMD_HI:`EXEC_CMD_LO];
    launch_in.array_byte_pointer = pwdata[`EXEC_PTR_HI:`EXEC_PTR_LO];
  end

  assign launch_wr = wr & hit_launch;
  // only the four defined codes are legal
  assign cmd_bad = (launch_in.cmd > 3'(CMD_STORE_PROT));
  // writing while a transfer runs is illegal
  assign launch_bad = launch_wr & (xfer_running | cmd_bad);
  // start only when legal and powered
  assign launch_go = launch_wr & ~xfer_running & ~cmd_bad & controller_on_r;

  ////////////////////////////////////////////////////////////////////////////////
  // local reset pulse

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      local_rst_r <= 1'b0;
    else
      local_rst_r <= wr & hit_mode & pwdata[`MODE_SOFT_RST_BIT];
  end

  // system reset asserts the local reset too
  assign block_local_reset = local_rst_r | ~presetn;

  ////////////////////////////////////////////////////////////////////////////////
  // controller mode

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      controller_on_r <= 1'b0;
    else if (local_rst_r)
      controller_on_r <= 1'b0;
    else if (wr & hit_mode)
      controller_on_r <= pwdata[`MODE_ON_BIT];
  end

  assign fabric_power_en = controller_on_r;

  ////////////////////////////////////////////////////////////////////////////////
  // transfer launch register

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      launch_r <= '0;
    else if (local_rst_r)
      launch_r <= '0;
    else if (launch_wr & ~launch_bad)
      launch_r <= launch_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt mask, kept over the local reset

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_r <= 2'h0;
    else if (wr & hit_mask)
      irq_mask_r <= pwdata[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transfer sequencer

  xfer_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .sync_clr(local_rst_r),
    .start(launch_go),
    .launch(launch_in),
    .fab_ack(fab_ack),
    .fab_rdata(fab_rdata),
    .buf_rdata(buf_rdata),
    .busy(xfer_running),
    .done(xfer_finished),
    .fab_req(fab_req),
    .buf_req(buf_req)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // status flags

  always_comb
  begin
    flag_set = '0;
    flag_set[`STAT_DONE_BIT] = xfer_finished;
    flag_set[`STAT_BAD_BIT] = launch_bad;
    flag_clr = '0;
    if (wr & hit_state)
      flag_clr = pwdata[`FLAG_N-1:0];
  end

  sticky_flags #(
    .N(`FLAG_N)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .sync_clr(local_rst_r),
    .set(flag_set),
    .clr(flag_clr),
    .flags(flags)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt

  always_comb
  begin
    irq = 1'b0;
    if (flags[`STAT_BAD_BIT] & irq_mask_r[`STAT_BAD_BIT])
      irq = 1'b1;
    if (flags[`STAT_DONE_BIT] & irq_mask_r[`STAT_DONE_BIT])
      irq = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register words as software reads them

  always_comb
  begin
    mode_word = `RESET_WORD;
    mode_word[`MODE_ON_BIT] = controller_on_r;
    launch_word = `RESET_WORD;
    launch_word[`EXEC_COUNT_HI:`EXEC_COUNT_LO] = launch_r.byte_count;
    launch_word[`EXEC_CMD_HI:`EXEC_CMD_LO] = launch_r.cmd;
    launch_word[`EXEC_PTR_HI:`EXEC_PTR_LO] = launch_r.array_byte_pointer;
    state_word = `RESET_WORD;
    state_word[`STAT_RUN_BIT] = xfer_running;
    state_word[`STAT_BAD_BIT] = flags[`STAT_BAD_BIT];
    state_word[`STAT_DONE_BIT] = flags[`STAT_DONE_BIT];
    mask_word = `RESET_WORD;
    mask_word[1:0] = irq_mask_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup cycle

  always_comb
  begin
    rd_nxt = `RESET_WORD;
    if (hit_mode)
      rd_nxt = mode_word;
    else if (hit_launch)
      rd_nxt = launch_word;
    else if (hit_state)
      rd_nxt = state_word;
    else if (hit_mask)
      rd_nxt = mask_word;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= `RESET_WORD;
    else if (setup & ~pwrite)
      prdata <= rd_nxt;
  end

endmodule

// ### test/eeprom_fabric_model.sv
// behavioural eeprom fabric and register buffer on the far side of the block
`timescale 1ns/1ps
module eeprom_fabric_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] lat,
  input eeprom_ctrl_pkg::fab_req_t fab_req,
  output logic fab_ack,
  output logic [7:0] fab_rdata,
  input eeprom_ctrl_pkg::buf_req_t buf_req,
  output logic [7:0] buf_rdata
);
  import eeprom_ctrl_pkg::*;
  logic [7:0] arr [0:2047];
  logic [7:0] bufm [0:31];
  logic [7:0] prot_r;
  logic [3:0] wait_r;
  initial
  begin
    for (int i = 0; i < 2048; i++) arr[i] = i[7:0] ^ 8'hA5;
    for (int i = 0; i < 32; i++) bufm[i] = 8'hEE;
    prot_r = 8'h3C;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // fabric answers one byte per request after lat idle cycles
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      fab_ack <= 1'b0;
      wait_r <= 4'h0;
      fab_rdata <= 8'h00;
    end
    else if (fab_req.req && !fab_ack && wait_r >= lat)
    begin
      fab_ack <= 1'b1;
      wait_r <= 4'h0;
      fab_rdata <= fab_req.prot ? prot_r : arr[fab_req.addr];
      if (fab_req.wr && fab_req.prot) prot_r <= fab_req.wdata;
      if (fab_req.wr && !fab_req.prot) arr[fab_req.addr] <= fab_req.wdata;
    end
    else
    begin
      fab_ack <= 1'b0;
      wait_r <= fab_req.req ? wait_r + 4'h1 : 4'h0;
      fab_rdata <= ~fab_rdata;
    end
  ////////////////////////////////////////////////////////////////////////////////
  // buffer with one cycle read latency
  always @(posedge pclk)
  begin
    if (buf_req.we) bufm[buf_req.waddr] <= buf_req.wdata;
    buf_rdata <= bufm[buf_req.raddr];
  end
endmodule

// ### test/eeprom_command_status_ctrl_sva.sv
// port assertions of the eeprom command/status block
`timescale 1ns/1ps
`include "eeprom_ctrl_consts.svh"
module eeprom_command_status_ctrl_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [`APB_DATA_W-1:0] pwdata,
  input wire logic [`APB_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic fabric_power_en,
  input wire logic block_local_reset,
  input eeprom_ctrl_pkg::fab_req_t fab_req,
  input wire logic fab_ack,
  input wire logic [`BYTE_W-1:0] fab_rdata,
  input eeprom_ctrl_pkg::buf_req_t buf_req,
  input wire logic [`BYTE_W-1:0] buf_rdata
);
  import eeprom_ctrl_pkg::*;
  logic acc;
  logic mwr;
  logic [1:0] mask_r;
  assign acc = psel && penable && pready;
  assign mwr = acc && pwrite && paddr == `OFF_CONTROLLER_MODE;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mask_r <= 2'h0;
    else if (acc && pwrite && paddr == `OFF_IRQ_MASK)
      mask_r <= pwdata[1:0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_power_wr;
    mwr && !pwdata[1] && !block_local_reset |=> fabric_power_en == $past(pwdata[0]);
  endproperty
  a_power_wr: assert property (p_power_wr) else $error("power enable wrong");
  property p_soft;
    mwr && pwdata[1] |=> block_local_reset ##1 (!fabric_power_en && !fab_req.req);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset wrong");
  property p_prot_addr;
    fab_req.req && fab_req.prot |-> fab_req.addr == 11'h000;
  endproperty
  a_prot_addr: assert property (p_prot_addr) else $error("pointer used");
  property p_prot_one;
    fab_ack && fab_req.req && fab_req.prot |=> !fab_req.req;
  endproperty
  a_prot_one: assert property (p_prot_one) else $error("count used");
  property p_req_hold;
    fab_req.req && !fab_ack && !block_local_reset |=> fab_req.req && $stable(fab_req.addr)
      && $stable(fab_req.wr) && $stable(fab_req.wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request disturbed");
  property p_irq_mask;
    mask_r == 2'h0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
  property p_state_rsvd;
    acc && !pwrite && paddr == `OFF_TRANSFER_STATE |-> prdata[31:9] == 23'h0 && prdata[7:2] == 6'h0;
  endproperty
  a_state_rsvd: assert property (p_state_rsvd) else $error("state bits");
  property p_launch_rsvd;
    acc && !pwrite && paddr == `OFF_TRANSFER_LAUNCH |-> (prdata & ~`EXEC_WR_MASK) == 32'h0000_0000;
  endproperty
  a_launch_rsvd: assert property (p_launch_rsvd) else $error("launch bits");
  property p_unmapped;
    acc && !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}) |-> pslverr
      && (pwrite || prdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access");
  c_write: cover property (fab_ack && fab_req.wr && !fab_req.prot);
  c_irq: cover property (irq);
  c_soft: cover property (block_local_reset);
endmodule
bind eeprom_command_status_ctrl eeprom_command_status_ctrl_sva u_sva (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .fabric_power_en,
  .block_local_reset, .fab_req, .fab_ack, .fab_rdata, .buf_req, .buf_rdata);

// ### test/tb_eeprom_command_status_ctrl.sv
// self-checking bench of the eeprom command/status block
`timescale 1ns/1ps
`include "eeprom_ctrl_consts.svh"
module tb_eeprom_command_status_ctrl;
  import eeprom_ctrl_pkg::*;
  localparam logic [11:0] md = `OFF_CONTROLLER_MODE;
  localparam logic [11:0] ln = `OFF_TRANSFER_LAUNCH;
  localparam logic [11:0] st = `OFF_TRANSFER_STATE;
  localparam logic [11:0] mk = `OFF_IRQ_MASK;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, pwr_en, blr, fab_ack, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] fab_rdata, buf_rdata;
  logic [3:0] lat;
  fab_req_t fab_req;
  buf_req_t buf_req;
  int fails = 0;
  int samples_checked = 0;
  eeprom_command_status_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .fabric_power_en(pwr_en),
    .block_local_reset(blr), .fab_req(fab_req), .fab_ack(fab_ack), .fab_rdata(fab_rdata),
    .buf_req(buf_req), .buf_rdata(buf_rdata));
  eeprom_fabric_model fab (.pclk(pclk), .presetn(presetn), .lat(lat), .fab_req(fab_req),
    .fab_ack(fab_ack), .fab_rdata(fab_rdata), .buf_req(buf_req), .buf_rdata(buf_rdata));
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(input int a);
    return a[7:0] ^ 8'hA5;
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, m);
  endtask
  task automatic launch(input logic [4:0] n, input logic [2:0] c, input logic [15:0] p);
    apb(1'b1, ln, {3'h0, n, 5'h00, c, p});
  endtask
  task automatic wait_done();
    do apb(1'b0, st, 32'h0000_0000); while (rd[0] !== 1'b1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdc(md, 32'h0000_0000, "mode reset");
    rdc(ln, 32'h0000_0000, "launch reset");
    rdc(st, 32'h0000_0000, "state reset");
    rdc(mk, 32'h0000_0000, "mask reset");
    rdc(12'h010, 32'h0000_0000, "unmapped");
    chk(err, 1'b1, "unmapped err");
    launch(5'h01, CMD_ARRAY_READ, 16'h0000);
    repeat (4) @(posedge pclk);
    chk(fab_req.req, 1'b0, "start while off");
    rdc(st, 32'h0000_0000, "flag while off");
    apb(1'b1, md, 32'h0000_0001);
    rdc(md, 32'h0000_0001, "mode on");
    chk(pwr_en, 1'b1, "power on");
  endtask
  task automatic t_read();
    lat <= 4'h3;
    apb(1'b1, mk, 32'h0000_0001);
    launch(5'h04, CMD_ARRAY_READ, 16'h07FE);
    rdc(st, 32'h0000_0100, "running");
    launch(5'h01, CMD_ARRAY_READ, 16'h0100);
    wait_done();
    chk(rd, 32'h0000_0003, "done busy");
    chk(irq, 1'b1, "done irq");
    for (int i = 0; i < 4; i++) chk(fab.bufm[i], pat((2046 + i) % 2048), "rd");
    chk(fab.bufm[4], 8'hEE, "rd count");
    apb(1'b1, st, 32'h0000_0003);
    rdc(st, 32'h0000_0000, "clear");
    chk(irq, 1'b0, "irq clear");
  endtask
  task automatic t_write();
    lat <= 4'h7;
    for (int i = 0; i < 32; i++) fab.bufm[i] = 8'(8'h40 + i);
    launch(5'h00, CMD_ARRAY_WRITE, 16'h0040);
    wait_done();
    for (int i = 0; i < 32; i++) chk(fab.arr[64 + i], 8'h40 + i, "wr");
    chk(fab.arr[96], pat(96), "wr past");
    apb(1'b1, st, 32'h0000_0001);
  endtask
  task automatic t_prot();
    lat <= 4'h0;
    launch(5'h05, CMD_FETCH_PROT, 16'h0123);
    wait_done();
    chk(fab.bufm[0], 8'h3C, "fetch");
    chk(fab.bufm[1], 8'h41, "fetch n");
    apb(1'b1, st, 32'h0000_0001);
    fab.bufm[0] = 8'h5A;
    launch(5'h05, CMD_STORE_PROT, 16'h0123);
    wait_done();
    chk(fab.prot_r, 8'h5A, "store");
    chk(fab.arr[291], pat(291), "ptr");
    apb(1'b1, st, 32'h0000_0001);
  endtask
  task automatic t_bad();
    for (int c = 4; c < 8; c++)
    begin
      apb(1'b1, mk, {30'h0, c[0], 1'b0});
      launch(5'h01, c[2:0], 16'h0000);
      repeat (4) @(posedge pclk);
      rdc(st, 32'h0000_0002, "bad code");
      chk(irq, c[0], "bad irq");
      apb(1'b1, st, 32'h0000_0002);
    end
    chk(fab.bufm[0], 8'h5A, "bad started");
  endtask
  task automatic t_soft();
    rdc(ln, {8'h05, 8'h03, 16'h0123}, "launch kept");
    apb(1'b1, md, 32'h0000_0003);
    rdc(md, 32'h0000_0000, "soft mode");
    rdc(ln, 32'h0000_0000, "soft launch");
    rdc(mk, 32'h0000_0002, "mask kept");
    chk(pwr_en, 1'b0, "soft power");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    lat = 4'h0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_read();
    t_write();
    t_prot();
    t_bad();
    t_soft();
    results();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    results();
  end
endmodule
